// File: src/bdr_pkg.sv
// Constants, types and the position mapping shared by the destination register block
package bdr_pkg;

    localparam int POS_W = 21;
    localparam int LOW_W = 12;
    localparam int HIGH_W = 9;
    localparam int DIM_W = 12;
    localparam int LINE_W = 10;
    localparam int LOC_W = 18;
    localparam int OFFSET_W = 16;
    localparam int PAGE_W = LOC_W - OFFSET_W;
    localparam int TEXT_SHIFT = 3;
    localparam int ADDR_W = 8;

    // Register indices carried in bits 15:12 of a host word; byte address is four times it
    localparam logic [3:0] IDX_DEST_LOW = 4'h4;
    localparam logic [3:0] IDX_DEST_HIGH = 4'h5;
    localparam logic [3:0] IDX_WIDTH = 4'h6;
    localparam logic [3:0] IDX_HEIGHT = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_DEST_LOW = {2'h0, IDX_DEST_LOW, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DEST_HIGH = {2'h0, IDX_DEST_HIGH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_WIDTH = {2'h0, IDX_WIDTH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_HEIGHT = {2'h0, IDX_HEIGHT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PORT = 8'h08;

    // Control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_PACKED = 1;
    localparam int CTRL_TEXT = 2;
    localparam int CTRL_LINE = 3;
    localparam int CTRL_QUICK = 4;
    localparam int CTRL_UPDATE = 5;
    localparam int CTRL_DLINEAR = 6;
    localparam int CTRL_DNOTMEM = 7;
    localparam int CTRL_SNOTMEM = 8;
    localparam int CTRL_W = 9;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;

    localparam logic [LOW_W-1:0] RST_DEST_LOW = 12'h000;
    localparam logic [HIGH_W-1:0] RST_DEST_HIGH = 9'h000;
    localparam logic [DIM_W-1:0] RST_DIM = 12'h001;
    localparam logic [CTRL_W-1:0] RST_CTRL = 9'h000;

    typedef enum logic [0:0] {ST_IDLE, ST_RUN} bdr_state_type;

    typedef struct packed {
        logic valid;
        logic all_maps;
        logic [LOC_W-1:0] location;
        logic [PAGE_W-1:0] page;
        logic [OFFSET_W-1:0] offset;
        logic [2:0] pixel_bit;
        logic [1:0] map;
    } bdr_map_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } bdr_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bdr_apb_rsp_type;

    // Planar: eight pixels per byte in all maps; packed: four pixels spread over the maps
    function automatic bdr_map_type bdr_map_position(input logic [POS_W-1:0] pos,
                                                     input logic packed_mode,
                                                     input logic is_mem);
        bdr_map_type m;
        m = '0;
        m.valid = is_mem;
        if (packed_mode) begin
            m.location = pos[LOC_W+1:2];
            m.map = pos[1:0];
        end else begin
            m.location = pos[LOC_W+2:3];
            m.pixel_bit = ~pos[2:0];
            m.all_maps = 1'b1;
        end
        m.page = m.location[LOC_W-1:OFFSET_W];
        m.offset = m.location[OFFSET_W-1:0];
        return m;
    endfunction

endpackage

// File: src/bdr_dest_regs.sv
// Destination position and region dimension registers with APB access and mapping
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

// Summary of operation
// - Destination low register, index 4, holds position bits 11:0.
// - Destination high register, index 5, holds bits 20:12; bits 11:9 written zero.
// - Positions are decoded per planar or packed mode, not as linear bytes.
// - A position names the pixel at the starting corner, top-left or bottom-right.
// - Planar: location is n/8 in all maps, pixel bit 7 minus n mod 8.
// - Packed: map n mod 4 at location n/4; map 0 is leftmost.
// - Planar positions reach 2M-1, giving 256K locations.
// - Packed positions reach 1M-1 for one megabyte.
// - Locations are byte offsets, pages treated as contiguous 64K pages.
// - Non-memory ends ignore positions; source low bits still give alignment.
// - Width register, index 6, gives region width of 1 to 2K.
// - Width is pixels in graphics, characters times eight in text modes.
// - Line drawing uses width bits 9:0 as X length.
// - Height register, index 7, gives region height of 1 to 2K.
// - Height is pixels in graphics, character rows in text modes.
// - Line drawing uses height bits 9:0 as Y length.
// - High and low fields join into a 21-bit starting corner address.
// - Quick start without auto-update starts a transfer on destination low write.
// - Auto-update moves destination just right of, or past, the finished region.
module bdr_dest_regs (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire bdr_pkg::bdr_apb_req_type APB_REQ,
    output bdr_pkg::bdr_apb_rsp_type APB_RSP,
    input wire logic [bdr_pkg::POS_W-1:0] SRC_POS,
    input wire logic SRC_LOW_WRITE,
    output bdr_pkg::bdr_map_type DEST_MAP,
    output bdr_pkg::bdr_map_type SRC_MAP,
    output logic [2:0] SRC_ALIGN,
    output logic [bdr_pkg::DIM_W-1:0] LEN_X,
    output logic [bdr_pkg::DIM_W-1:0] LEN_Y,
    output logic [bdr_pkg::DIM_W-1:0] COUNT_X,
    output logic [bdr_pkg::DIM_W-1:0] COUNT_Y,
    output logic XFER_START,
    output logic XFER_BUSY,
    output logic XFER_DONE
);
    import bdr_pkg::*;

    typedef struct packed {
        logic [LOW_W-1:0] dest_low;
        logic [HIGH_W-1:0] dest_high;
        logic [DIM_W-1:0] width;
        logic [DIM_W-1:0] height;
        logic [CTRL_W-1:0] ctrl;
        logic done_flag;
        bdr_state_type state;
        logic [DIM_W-1:0] len_x;
        logic [DIM_W-1:0] len_y;
        logic [DIM_W-1:0] cnt_x;
        logic [DIM_W-1:0] cnt_y;
        logic start_p;
        logic done_p;
        bdr_apb_rsp_type rsp;
        bdr_map_type dest_map;
        bdr_map_type src_map;
        logic [2:0] src_align;
    } bdr_regs_type;

    localparam bdr_regs_type RST_REGS = '{
        dest_low: RST_DEST_LOW,
        dest_high: RST_DEST_HIGH,
        width: RST_DIM,
        height: RST_DIM,
        ctrl: RST_CTRL,
        done_flag: 1'b0,
        state: ST_IDLE,
        len_x: RST_DIM,
        len_y: RST_DIM,
        cnt_x: '0,
        cnt_y: '0,
        start_p: 1'b0,
        done_p: 1'b0,
        rsp: '0,
        // Map of position zero, so the output agrees with the cleared registers
        dest_map: '{valid: 1'b1, all_maps: 1'b1, pixel_bit: 3'h7, default: '0},
        src_map: '0,
        src_align: 3'h0
    };

    bdr_regs_type r;
    bdr_regs_type r_nxt;

    logic setup;
    logic wr_acc;
    logic [3:0] port_idx;
    logic wr_low;
    logic wr_high;
    logic wr_width;
    logic wr_height;
    logic [POS_W-1:0] dest_pos;
    logic [POS_W-1:0] dest_step;
    logic [2*DIM_W-1:0] area;
    logic start_req;
    logic last_step;
    logic mapped;
    logic [31:0] rd_data;

    // Zero lengths are out of range for software; treat them as one to keep the walk finite
    function automatic logic [DIM_W-1:0] bdr_at_least_one(input logic [DIM_W-1:0] v);
        return (v == '0) ? {{(DIM_W-1){1'b0}}, 1'b1} : v;
    endfunction

    always_comb begin
        r_nxt = r;
        setup = APB_REQ.psel && !APB_REQ.penable;
        wr_acc = APB_REQ.psel && APB_REQ.penable && r.rsp.pready && APB_REQ.pwrite;
        port_idx = APB_REQ.pwdata[15:12];
        wr_low = wr_acc && ((APB_REQ.paddr == ADDR_DEST_LOW) ||
                 (APB_REQ.paddr == ADDR_PORT && port_idx == IDX_DEST_LOW));
        wr_high = wr_acc && ((APB_REQ.paddr == ADDR_DEST_HIGH) ||
                  (APB_REQ.paddr == ADDR_PORT && port_idx == IDX_DEST_HIGH));
        wr_width = wr_acc && ((APB_REQ.paddr == ADDR_WIDTH) ||
                   (APB_REQ.paddr == ADDR_PORT && port_idx == IDX_WIDTH));
        wr_height = wr_acc && ((APB_REQ.paddr == ADDR_HEIGHT) ||
                    (APB_REQ.paddr == ADDR_PORT && port_idx == IDX_HEIGHT));
        dest_pos = {r.dest_high, r.dest_low};
        area = r.len_x * r.len_y;
        // Linear regions advance past the whole area, rectangular ones by one width
        dest_step = r.ctrl[CTRL_DLINEAR] ? area[POS_W-1:0]
                                         : {{(POS_W-DIM_W){1'b0}}, r.width};
        last_step = (r.cnt_x == r.len_x - 1'b1) && (r.cnt_y == r.len_y - 1'b1);

        // Register file writes, data field only
        if (wr_low) begin
            r_nxt.dest_low = APB_REQ.pwdata[LOW_W-1:0];
        end
        if (wr_high) begin
            r_nxt.dest_high = APB_REQ.pwdata[HIGH_W-1:0];
        end
        if (wr_width) begin
            r_nxt.width = APB_REQ.pwdata[DIM_W-1:0];
        end
        if (wr_height) begin
            r_nxt.height = APB_REQ.pwdata[DIM_W-1:0];
        end
        if (wr_acc && APB_REQ.paddr == ADDR_CTRL) begin
            r_nxt.ctrl = APB_REQ.pwdata[CTRL_W-1:0];
            r_nxt.ctrl[CTRL_START] = 1'b0;
        end
        if (wr_acc && APB_REQ.paddr == ADDR_STATUS && APB_REQ.pwdata[STAT_DONE]) begin
            r_nxt.done_flag = 1'b0;
        end

        // Start sources: explicit bit, quick start on destination low, or on source low
        start_req = (wr_acc && APB_REQ.paddr == ADDR_CTRL && APB_REQ.pwdata[CTRL_START]) ||
                    (wr_low && r.ctrl[CTRL_QUICK] && !r.ctrl[CTRL_UPDATE]) ||
                    (SRC_LOW_WRITE && r.ctrl[CTRL_QUICK] && r.ctrl[CTRL_UPDATE]);

        r_nxt.start_p = 1'b0;
        r_nxt.done_p = 1'b0;
        case (r.state)
            ST_IDLE: begin
                if (start_req) begin
                    r_nxt.state = ST_RUN;
                    r_nxt.start_p = 1'b1;
                    r_nxt.cnt_x = '0;
                    r_nxt.cnt_y = '0;
                    // Mode bits written together with the start bit govern this transfer
                    if (r_nxt.ctrl[CTRL_LINE]) begin
                        r_nxt.len_x = bdr_at_least_one({2'h0, r.width[LINE_W-1:0]});
                        r_nxt.len_y = bdr_at_least_one({2'h0, r.height[LINE_W-1:0]});
                    end else if (r_nxt.ctrl[CTRL_TEXT]) begin
                        r_nxt.len_x = bdr_at_least_one(r.width >> TEXT_SHIFT);
                        r_nxt.len_y = bdr_at_least_one(r.height);
                    end else begin
                        r_nxt.len_x = bdr_at_least_one(r.width);
                        r_nxt.len_y = bdr_at_least_one(r.height);
                    end
                end
            end
            ST_RUN: begin
                if (last_step) begin
                    r_nxt.state = ST_IDLE;
                    r_nxt.done_p = 1'b1;
                    r_nxt.done_flag = 1'b1;
                    if (r.ctrl[CTRL_UPDATE]) begin
                        {r_nxt.dest_high, r_nxt.dest_low} = dest_pos + dest_step;
                    end
                end else if (r.cnt_x == r.len_x - 1'b1) begin
                    r_nxt.cnt_x = '0;
                    r_nxt.cnt_y = r.cnt_y + 1'b1;
                end else begin
                    r_nxt.cnt_x = r.cnt_x + 1'b1;
                end
            end
            default: begin
                r_nxt.state = ST_IDLE;
            end
        endcase
        r_nxt.ctrl[CTRL_START] = (r_nxt.state == ST_RUN);

        // Position decoding follows the address mode; non-memory ends are flagged invalid
        r_nxt.dest_map = bdr_map_position(dest_pos, r.ctrl[CTRL_PACKED],
                                          !r.ctrl[CTRL_DNOTMEM]);
        r_nxt.src_map = bdr_map_position(SRC_POS, r.ctrl[CTRL_PACKED],
                                         !r.ctrl[CTRL_SNOTMEM]);
        r_nxt.src_align = r.ctrl[CTRL_PACKED] ? {1'b0, SRC_POS[1:0]} : SRC_POS[2:0];

        // APB: answer in the first access cycle, data captured in setup
        mapped = 1'b1;
        rd_data = 32'h0000_0000;
        case (APB_REQ.paddr)
            ADDR_DEST_LOW: rd_data = {16'h0000, IDX_DEST_LOW, r.dest_low};
            ADDR_DEST_HIGH: rd_data = {16'h0000, IDX_DEST_HIGH, 3'h0, r.dest_high};
            ADDR_WIDTH: rd_data = {16'h0000, IDX_WIDTH, r.width};
            ADDR_HEIGHT: rd_data = {16'h0000, IDX_HEIGHT, r.height};
            ADDR_CTRL: rd_data = {23'h000000, r.ctrl};
            ADDR_STATUS: rd_data = {30'h00000000, r.done_flag, r.state == ST_RUN};
            ADDR_PORT: rd_data = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
        r_nxt.rsp.pready = setup;
        if (setup) begin
            r_nxt.rsp.prdata = APB_REQ.pwrite ? 32'h0000_0000 : rd_data;
            r_nxt.rsp.pslverr = !mapped;
        end else if (!APB_REQ.psel) begin
            r_nxt.rsp.prdata = 32'h0000_0000;
            r_nxt.rsp.pslverr = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            r <= RST_REGS;
        end else begin
            r <= r_nxt;
        end
    end

    assign APB_RSP = r.rsp;
    assign DEST_MAP = r.dest_map;
    assign SRC_MAP = r.src_map;
    assign SRC_ALIGN = r.src_align;
    assign LEN_X = r.len_x;
    assign LEN_Y = r.len_y;
    assign COUNT_X = r.cnt_x;
    assign COUNT_Y = r.cnt_y;
    assign XFER_START = r.start_p;
    assign XFER_BUSY = r.ctrl[CTRL_START];
    assign XFER_DONE = r.done_p;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    a_port_low_write: assert property (
        (APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite &&
         APB_REQ.paddr == ADDR_PORT && APB_REQ.pwdata[15:12] == IDX_DEST_LOW &&
         !(r.state == ST_RUN && last_step && r.ctrl[CTRL_UPDATE]))
        |=> (r.dest_low == $past(APB_REQ.pwdata[11:0])))
        else $error("destination low not loaded from port word");

    a_high_reserved_zero: assert property (
        (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite &&
         APB_REQ.paddr == ADDR_DEST_HIGH) |=> (APB_RSP.prdata[11:9] == 3'h0 && APB_RSP.pready))
        else $error("destination high reserved bits not zero");

    a_planar_pixel_map: assert property (
        (!r.ctrl[CTRL_PACKED] && $stable(dest_pos)) |=>
        (DEST_MAP.location == $past(dest_pos[20:3]) &&
         DEST_MAP.pixel_bit == 3'h7 - $past(dest_pos[2:0]) && DEST_MAP.all_maps))
        else $error("planar position mapped wrongly");

    a_packed_pixel_map: assert property (
        (r.ctrl[CTRL_PACKED] && $stable(dest_pos)) |=>
        (DEST_MAP.location == $past(dest_pos[19:2]) && DEST_MAP.map == $past(dest_pos[1:0])))
        else $error("packed position mapped wrongly");

    a_not_mem_invalid: assert property (
        r.ctrl[CTRL_DNOTMEM] |=> !DEST_MAP.valid)
        else $error("non-memory destination flagged valid");

    a_quick_start_go: assert property (
        (r.state == ST_IDLE && wr_low && r.ctrl[CTRL_QUICK] && !r.ctrl[CTRL_UPDATE])
        |=> (XFER_START && XFER_BUSY) ##1 !XFER_START)
        else $error("quick start did not start a transfer");

    a_quick_start_held: assert property (
        (r.state == ST_IDLE && wr_low && !SRC_LOW_WRITE && r.ctrl[CTRL_UPDATE] &&
         !(APB_REQ.paddr == ADDR_CTRL)) |=> !XFER_START)
        else $error("destination write started transfer under auto-update");

    a_auto_update_step: assert property (
        (r.state == ST_RUN && last_step && r.ctrl[CTRL_UPDATE] && !r.ctrl[CTRL_DLINEAR])
        |=> (dest_pos == $past(dest_pos) + $past({9'h000, r.width}) && XFER_DONE))
        else $error("destination not advanced by one width");

    a_line_lengths: assert property (
        (r.state == ST_IDLE && start_req && r_nxt.ctrl[CTRL_LINE] && r.width[9:0] != 10'h000)
        |=> (LEN_X == {2'h0, $past(r.width[9:0])}))
        else $error("line X length not taken from low ten bits");

    a_text_width: assert property (
        (r.state == ST_IDLE && start_req && !r_nxt.ctrl[CTRL_LINE] && r_nxt.ctrl[CTRL_TEXT] &&
         r.width[11:3] != 9'h000) |=> (LEN_X == ($past(r.width) >> 3)))
        else $error("text width not divided by eight");

    a_low_direct_write: assert property (
        (wr_acc && APB_REQ.paddr == ADDR_DEST_LOW &&
         !(r.state == ST_RUN && last_step && r.ctrl[CTRL_UPDATE]))
        |=> (r.dest_low == $past(APB_REQ.pwdata[11:0])))
        else $error("destination low not loaded from bus");

    a_high_direct_write: assert property (
        (wr_acc && APB_REQ.paddr == ADDR_DEST_HIGH &&
         !(r.state == ST_RUN && last_step && r.ctrl[CTRL_UPDATE]))
        |=> (r.dest_high == $past(APB_REQ.pwdata[8:0])))
        else $error("destination high not loaded from bus");

    a_width_write: assert property (
        (wr_acc && APB_REQ.paddr == ADDR_WIDTH)
        |=> (r.width == $past(APB_REQ.pwdata[11:0])))
        else $error("width register not loaded");

    a_height_write: assert property (
        (wr_acc && APB_REQ.paddr == ADDR_HEIGHT)
        |=> (r.height == $past(APB_REQ.pwdata[11:0])))
        else $error("height register not loaded");

    a_port_foreign_index: assert property (
        (wr_acc && APB_REQ.paddr == ADDR_PORT &&
         (APB_REQ.pwdata[15:12] < IDX_DEST_LOW || APB_REQ.pwdata[15:12] > IDX_HEIGHT))
        |=> ($stable(r.width) && $stable(r.height)))
        else $error("port word with foreign index changed a register");

    a_graph_width: assert property (
        (r.state == ST_IDLE && start_req && !r_nxt.ctrl[CTRL_LINE] && !r_nxt.ctrl[CTRL_TEXT] &&
         r.width != 12'h000) |=> (LEN_X == $past(r.width)))
        else $error("graphics width not taken in pixels");

    a_region_height: assert property (
        (r.state == ST_IDLE && start_req && !r_nxt.ctrl[CTRL_LINE] && r.height != 12'h000)
        |=> (LEN_Y == $past(r.height)))
        else $error("region height not taken as rows or pixels");

    a_line_y_length: assert property (
        (r.state == ST_IDLE && start_req && r_nxt.ctrl[CTRL_LINE] && r.height[9:0] != 10'h000)
        |=> (LEN_Y == {2'h0, $past(r.height[9:0])}))
        else $error("line Y length not taken from low ten bits");

    a_linear_step: assert property (
        (r.state == ST_RUN && last_step && r.ctrl[CTRL_UPDATE] && r.ctrl[CTRL_DLINEAR])
        |=> (dest_pos == $past(dest_pos) + $past({9'h000, LEN_X} * {9'h000, LEN_Y})))
        else $error("destination not advanced past a linear region");

    a_src_not_mem: assert property (
        r.ctrl[CTRL_SNOTMEM] |=> !SRC_MAP.valid)
        else $error("non-memory source flagged valid");

    a_align_planar: assert property (
        !r.ctrl[CTRL_PACKED] |=> (SRC_ALIGN == $past(SRC_POS[2:0])))
        else $error("planar source alignment wrong");

    a_align_packed: assert property (
        r.ctrl[CTRL_PACKED] |=> (SRC_ALIGN == {1'b0, $past(SRC_POS[1:0])}))
        else $error("packed source alignment wrong");

    a_page_offset: assert property (
        !r.ctrl[CTRL_PACKED] |=>
        (DEST_MAP.offset == $past(dest_pos[18:3]) && DEST_MAP.page == $past(dest_pos[20:19])))
        else $error("planar page or offset wrong");

    a_planar_top: assert property (
        (!r.ctrl[CTRL_PACKED] && SRC_POS == 21'h1fffff)
        |=> (SRC_MAP.location == 18'h3ffff && SRC_MAP.pixel_bit == 3'h0))
        else $error("planar top position not at last location");

    a_packed_top: assert property (
        (r.ctrl[CTRL_PACKED] && SRC_POS == 21'h0fffff)
        |=> (SRC_MAP.location == 18'h3ffff && SRC_MAP.map == 2'h3))
        else $error("packed top position not at last location");

    a_source_quick_start: assert property (
        (r.state == ST_IDLE && SRC_LOW_WRITE && r.ctrl[CTRL_QUICK] && r.ctrl[CTRL_UPDATE])
        |=> (XFER_START && XFER_BUSY))
        else $error("source write did not start a transfer");

endmodule // bdr_dest_regs

// File: bench/blit_dest_dim_address_regs_bench.sv
// Self-checking bench for the destination position and dimension registers
`timescale 1ns/1ps
module blit_dest_dim_address_regs_bench;
    import bdr_pkg::*;
    logic clock;
    logic rst_n;
    bdr_apb_req_type apb_req;
    bdr_apb_rsp_type apb_rsp;
    logic [POS_W-1:0] src_pos;
    logic src_low_write;
    bdr_map_type dest_map;
    bdr_map_type src_map;
    logic [2:0] src_align;
    logic [DIM_W-1:0] len_x;
    logic [DIM_W-1:0] len_y;
    logic xfer_start;
    logic xfer_busy;
    logic xfer_done;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    bdr_dest_regs dut (.CLOCK(clock), .RST_N(rst_n), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
        .SRC_POS(src_pos), .SRC_LOW_WRITE(src_low_write), .DEST_MAP(dest_map),
        .SRC_MAP(src_map), .SRC_ALIGN(src_align), .LEN_X(len_x), .LEN_Y(len_y),
        .COUNT_X(), .COUNT_Y(), .XFER_START(xfer_start), .XFER_BUSY(xfer_busy),
        .XFER_DONE(xfer_done));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_of_test;
        $display("Mismatches %0d comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole run needs well under two thousand cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            $display("Error run_length expected below %0d seen %0d", 20000, cycles);
            end_of_test;
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Expected map worked out arithmetically from the position value
    function automatic bdr_map_type em(input logic [20:0] p, input logic pk, input logic mem);
        bdr_map_type m;
        m = '0;
        m.valid = mem;
        if (pk) begin
            m.location = LOC_W'(p / 4);
            m.map = 2'(p % 4);
        end else begin
            m.location = LOC_W'(p / 8);
            m.pixel_bit = 3'(7 - (p % 8));
            m.all_maps = 1'b1;
        end
        m.page = PAGE_W'(m.location / 65536);
        m.offset = OFFSET_W'(m.location % 65536);
        return m;
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge clock);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= wd;
        @(posedge clock);
        apb_req.penable <= 1'b1;
        // Look between edges: the ready flop changes in the very step of the rising edge
        do @(negedge clock); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        @(posedge clock);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, e, rd);
    endtask

    task automatic run_xfer(input logic [31:0] ctrl, input int lx, input int ly);
        int n;
        n = 0;
        wr(ADDR_CTRL, ctrl | (32'h1 << CTRL_START));
        settle(0);
        chk("xfer_start", 1, xfer_start);
        chk("len_x", 64'(lx), len_x);
        chk("len_y", 64'(ly), len_y);
        while (xfer_done !== 1'b1) begin
            if (xfer_busy === 1'b1) n = n + 1;
            settle(1);
        end
        chk("busy_cycles", 64'(lx * ly), 64'(n));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_done", 1, rd[STAT_DONE]);
        wr(ADDR_STATUS, 32'h1 << STAT_DONE);
    endtask

    task automatic t_reset;
        rdchk("dest_low", ADDR_DEST_LOW, 32'h00004000);
        rdchk("dest_high", ADDR_DEST_HIGH, 32'h00005000);
        rdchk("width", ADDR_WIDTH, 32'h00006001);
        rdchk("height", ADDR_HEIGHT, 32'h00007001);
    endtask

    task automatic t_position;
        wr(ADDR_DEST_LOW, 32'hffff_f123);
        wr(ADDR_DEST_HIGH, 32'h0000_00ab);
        rdchk("dest_low", ADDR_DEST_LOW, 32'h00004123);
        rdchk("dest_high", ADDR_DEST_HIGH, 32'h000050ab);
        settle(2);
        chk("dest_map_planar", em(21'h0ab123, 0, 1), dest_map);
        wr(ADDR_CTRL, 32'h1 << CTRL_PACKED);
        settle(2);
        chk("dest_map_packed", em(21'h0ab123, 1, 1), dest_map);
        wr(ADDR_CTRL, (32'h1 << CTRL_PACKED) | (32'h1 << CTRL_DNOTMEM));
        @(posedge clock);
        src_pos <= 21'h0fffff;
        settle(2);
        chk("dest_valid", 0, dest_map.valid);
        chk("src_map_top", em(21'h0fffff, 1, 1), src_map);
        chk("src_align_packed", 3, src_align);
        wr(ADDR_CTRL, 32'h1 << CTRL_SNOTMEM);
        @(posedge clock);
        src_pos <= 21'h1fffff;
        settle(2);
        chk("src_map_top", em(21'h1fffff, 0, 0), src_map);
        chk("src_align_planar", 7, src_align);
        wr(ADDR_CTRL, 32'h0);
    endtask

    task automatic t_port;
        wr(ADDR_PORT, 32'h0000_6234);
        rdchk("width", ADDR_WIDTH, 32'h00006234);
        wr(ADDR_PORT, 32'h0000_9555);
        rdchk("width", ADDR_WIDTH, 32'h00006234);
        wr(ADDR_PORT, 32'h0000_700a);
        rdchk("height", ADDR_HEIGHT, 32'h0000700a);
        wr(ADDR_PORT, 32'h0000_4abc);
        rdchk("dest_low", ADDR_DEST_LOW, 32'h00004abc);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
    endtask

    task automatic t_graphics;
        wr(ADDR_DEST_LOW, 32'h100);
        wr(ADDR_DEST_HIGH, 32'h0);
        wr(ADDR_WIDTH, 32'h3);
        wr(ADDR_HEIGHT, 32'h2);
        run_xfer(32'h1 << CTRL_UPDATE, 3, 2);
        rdchk("dest_low", ADDR_DEST_LOW, 32'h00004103);
    endtask

    task automatic t_text;
        wr(ADDR_DEST_LOW, 32'hffe);
        wr(ADDR_WIDTH, 32'h10);
        wr(ADDR_HEIGHT, 32'h3);
        // Linear region: next destination lies just past six units, carrying into high
        run_xfer((32'h1 << CTRL_TEXT) | (32'h1 << CTRL_UPDATE) | (32'h1 << CTRL_DLINEAR), 2, 3);
        rdchk("dest_low", ADDR_DEST_LOW, 32'h00004004);
        rdchk("dest_high", ADDR_DEST_HIGH, 32'h00005001);
    endtask

    task automatic t_line;
        wr(ADDR_WIDTH, 32'h402);
        wr(ADDR_HEIGHT, 32'h401);
        run_xfer(32'h1 << CTRL_LINE, 2, 1);
    endtask

    task automatic t_quick;
        wr(ADDR_WIDTH, 32'h1);
        wr(ADDR_HEIGHT, 32'h1);
        wr(ADDR_CTRL, 32'h1 << CTRL_QUICK);
        wr(ADDR_DEST_LOW, 32'h10);
        settle(0);
        chk("quick_start", 1, xfer_start);
        while (xfer_done !== 1'b1) settle(1);
        wr(ADDR_CTRL, (32'h1 << CTRL_QUICK) | (32'h1 << CTRL_UPDATE));
        wr(ADDR_DEST_LOW, 32'h20);
        settle(2);
        chk("no_start_on_dest", 0, xfer_busy);
        @(posedge clock);
        src_low_write <= 1'b1;
        @(posedge clock);
        src_low_write <= 1'b0;
        settle(0);
        chk("start_on_source", 1, xfer_start);
        while (xfer_done !== 1'b1) settle(1);
        wr(ADDR_CTRL, 32'h0);
    endtask

    initial begin
        rst_n = 1'b0;
        apb_req = '0;
        src_pos = '0;
        src_low_write = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        chk("len_x_in_reset", 1, len_x);
        @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_position();
        t_port();
        t_graphics();
        t_text();
        t_line();
        t_quick();
        end_of_test();
    end
endmodule // blit_dest_dim_address_regs_bench
